//--- hdl/ssp_pkg.sv
// Purpose: shared constants and types of the serial port block
// Assumes: AXI4-Lite register access, 8-bit registers in the low lane
// Notes:   struct layouts follow the register bit layouts
package ssp_pkg;
    // ********************
    // register map
    // ********************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_BUF  = 8'h08;
    localparam logic [7:0] OFS_FLAG = 8'h0C;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ********************
    // mode field codes
    // ********************
    localparam logic [3:0] MODE_M4    = 4'h0;
    localparam logic [3:0] MODE_M16   = 4'h1;
    localparam logic [3:0] MODE_M64   = 4'h2;
    localparam logic [3:0] MODE_MT2   = 4'h3;
    localparam logic [3:0] MODE_S_SS  = 4'h4;
    localparam logic [3:0] MODE_S_NSS = 4'h5;

    // ********************
    // timing: core clocks per serial clock half period, then last bit and edge counts
    // ********************
    localparam logic [5:0] HALF_DIV4  = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    localparam logic [3:0] LAST_BIT   = 4'h7;
    localparam logic [4:0] LAST_EDGE  = 5'h0F;
    localparam logic [4:0] END_TICK   = 5'h10;

    typedef struct packed {
        logic       write_collision;
        logic       receive_overflow;
        logic       port_enable;
        logic       clock_polarity;
        logic [3:0] mode_field;
    } ssp_ctrl_s;

    typedef struct packed {
        logic       sample_point;
        logic       clock_edge;
        logic       data_addr;
        logic       stop_seen;
        logic       start_seen;
        logic       read_write;
        logic       update_addr;
        logic       buffer_full;
    } ssp_stat_s;

    typedef struct packed {
        logic sck;
        logic sck_oe;
        logic sdo;
        logic sdo_oe;
        logic owned;
    } ssp_pins_s;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_MASTER = 3'b010,
        ST_SLAVE  = 3'b100
    } ssp_state_e;
endpackage : ssp_pkg

//--- hdl/ssp_spi_port.sv
// Purpose: SPI mode of a synchronous serial port, AXI4-Lite registers
// Assumes: clk is the oscillator; timer_two_tick is a one-clock pulse
// Notes:   pins are sampled through two flops, so select and clock
//          reactions lag the pins by two to three clocks
// How it works
// - eight bit words, full duplex, all four modes
// - finished word goes to buffer, sets flag
// - buffer write loads buffer and shifter together
// - status: only top two bits writable
// - master sample point: end or middle
// - clock edge bit picks transmit edge
// - stop bit cleared while port disabled
// - buffer full shows an unread received word
// - write while shifting sets write collision
// - slave overrun sets overflow, drops word
// - master never sets overflow
// - enable hands pins to the port
// - clock polarity sets idle clock level
// - master rates: osc/4, /16, /64, timer/2
// - mode 0100: slave with select
// - mode 0101: slave without select
// - status resets to zero
// - most significant bit first
// - buffer read clears buffer full
// - master starts on buffer write
// - select high floats output, clears count
`timescale 1ns/1ps
module ssp_spi_port (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                reset,
    // axi4-lite write
    input  wire logic [7:0]          axi_awaddr,
    input  wire logic                axi_awvalid,
    output      logic                axi_awready,
    input  wire logic [31:0]         axi_wdata,
    input  wire logic [3:0]          axi_wstrb,
    input  wire logic                axi_wvalid,
    output      logic                axi_wready,
    output      logic [1:0]          axi_bresp,
    output      logic                axi_bvalid,
    input  wire logic                axi_bready,
    // axi4-lite read
    input  wire logic [7:0]          axi_araddr,
    input  wire logic                axi_arvalid,
    output      logic                axi_arready,
    output      logic [31:0]         axi_rdata,
    output      logic [1:0]          axi_rresp,
    output      logic                axi_rvalid,
    input  wire logic                axi_rready,
    // serial link
    input  wire logic                sck_i,
    input  wire logic                sdi_i,
    input  wire logic                ss_n_i,
    input  wire logic                timer_two_tick,
    output      ssp_pkg::ssp_pins_s  pins
);
    import ssp_pkg::*;

    ssp_ctrl_s   ctrl;
    ssp_stat_s   stat;
    ssp_state_e  state;
    logic [7:0]  data_buffer;
    logic [7:0]  sr;
    logic        flag;
    logic [4:0]  tick_cnt;
    logic [3:0]  rx_cnt;
    logic [5:0]  div_cnt;
    logic [2:0]  sck_sy;
    logic [1:0]  sdi_sy;
    logic [1:0]  ss_sy;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [31:0] wdat;
    logic [3:0]  wstb;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFS_CTRL) || (a == OFS_STAT) || (a == OFS_BUF) || (a == OFS_FLAG);
    endfunction : mapped

    function automatic logic [5:0] half_of(input logic [3:0] m);
        half_of = (m == MODE_M64) ? HALF_DIV64 : (m == MODE_M16) ? HALF_DIV16 : HALF_DIV4;
    endfunction : half_of

    // ********************
    // pin synchronisers
    // ********************
    always_ff @(posedge clk) begin
        if (reset) begin
            sck_sy <= 3'h0;
            sdi_sy <= 2'h0;
            ss_sy  <= 2'h3;
        end else begin
            sck_sy <= {sck_sy[1:0], sck_i};
            sdi_sy <= {sdi_sy[0], sdi_i};
            ss_sy  <= {ss_sy[0], ss_n_i};
        end
    end

    // ********************
    // decode and shift events
    // ********************
    logic aw_hs, w_hs, ar_hs, do_wr, wr_buf, wr_ctrl, wr_stat, wr_flag, rd_buf;
    logic is_master, is_slave, ss_ctl, slave_sel, shifting, collide, load, start;
    logic master_tick, tick, samp, xmit, word_done, overrun;
    logic [7:0] next_word;

    assign aw_hs     = axi_awvalid && axi_awready;
    assign w_hs      = axi_wvalid && axi_wready;
    assign ar_hs     = axi_arvalid && axi_arready;
    assign do_wr     = aw_got && w_got && !axi_bvalid;
    assign wr_ctrl   = do_wr && wstb[0] && (waddr == OFS_CTRL);
    assign wr_stat   = do_wr && wstb[0] && (waddr == OFS_STAT);
    assign wr_buf    = do_wr && wstb[0] && (waddr == OFS_BUF);
    assign wr_flag   = do_wr && wstb[0] && (waddr == OFS_FLAG);
    assign rd_buf    = ar_hs && (axi_araddr == OFS_BUF);
    assign is_master = (ctrl.mode_field[3:2] == 2'h0);
    assign ss_ctl    = (ctrl.mode_field == MODE_S_SS);
    assign is_slave  = ss_ctl || (ctrl.mode_field == MODE_S_NSS);
    // select is ignored unless the mode asks for it
    assign slave_sel = ss_ctl ? !ss_sy[1] : 1'b1;
    assign shifting  = (state == ST_MASTER) || (state == ST_SLAVE && tick_cnt != 5'h0);
    assign collide   = wr_buf && ctrl.port_enable && shifting;
    assign load      = wr_buf && !collide;
    assign start     = load && ctrl.port_enable && is_master && state == ST_IDLE;
    assign master_tick = (state == ST_MASTER)
                       && ((ctrl.mode_field == MODE_MT2) ? timer_two_tick : div_cnt == 6'h0);
    // edges seen only while selected; sck_sy[0] feeds nothing but sck_sy[1]
    assign tick      = master_tick
                     || (state == ST_SLAVE && slave_sel && (sck_sy[1] ^ sck_sy[2]));
    // even ticks lead away from idle, odd ticks return; slave relies on
    // software keeping sample_point clear
    // clock_edge set transmits on the leading tick, clear on the returning one
    assign samp      = tick && rx_cnt <= LAST_BIT
                     && (tick_cnt[0] == (stat.clock_edge ^ stat.sample_point))
                     && !(tick_cnt == 5'h0 && (stat.clock_edge || stat.sample_point));
    assign xmit      = tick && (tick_cnt[0] != stat.clock_edge);
    assign next_word = {sr[6:0], sdi_sy[1]};
    assign word_done = samp && rx_cnt == LAST_BIT;
    assign overrun   = word_done && state == ST_SLAVE && stat.buffer_full;

    // ********************
    // transfer state
    // ********************
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (ctrl.port_enable && is_slave) begin
                        state <= ST_SLAVE;
                    end else if (start) begin
                        state <= ST_MASTER;
                    end
                end
                ST_MASTER: begin
                    if (!ctrl.port_enable || (master_tick && tick_cnt == END_TICK)) begin
                        state <= ST_IDLE;
                    end
                end
                ST_SLAVE: begin
                    if (!ctrl.port_enable || !is_slave) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            div_cnt <= 6'h0;
        end else if (start || master_tick) begin
            div_cnt <= half_of(ctrl.mode_field) - 6'h1;
        end else if (div_cnt != 6'h0) begin
            div_cnt <= div_cnt - 6'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tick_cnt <= 5'h0;
            rx_cnt   <= 4'h0;
        end else if (!ctrl.port_enable || start
                     || (state == ST_SLAVE && ss_ctl && ss_sy[1])) begin
            tick_cnt <= 5'h0;
            rx_cnt   <= 4'h0;
        end else begin
            if (tick) begin
                // slave wraps after sixteen edges, master stops at the end tick
                tick_cnt <= (state == ST_SLAVE && tick_cnt == LAST_EDGE) ? 5'h0
                                                                         : tick_cnt + 5'h1;
            end
            if (samp) begin
                rx_cnt <= word_done ? 4'h0 : rx_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sr <= 8'h0;
        end else if (load) begin
            sr <= wdat[7:0];
        end else if (samp) begin
            sr <= next_word;
        end
    end

    // ********************
    // pins
    // ********************
    always_ff @(posedge clk) begin
        if (reset) begin
            pins <= '0;
        end else begin
            pins.owned  <= ctrl.port_enable;
            pins.sck_oe <= ctrl.port_enable && is_master;
            // select high floats the output even mid-word
            pins.sdo_oe <= ctrl.port_enable && (is_master || (is_slave && slave_sel));
            if (state != ST_MASTER) begin
                pins.sck <= ctrl.clock_polarity;
            end else if (master_tick && tick_cnt <= LAST_EDGE) begin
                pins.sck <= !pins.sck;
            end
            if (load) begin
                pins.sdo <= wdat[7];
            end else if (xmit) begin
                pins.sdo <= samp ? sr[6] : sr[7];
            end
        end
    end

    // ********************
    // registers
    // ********************
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl <= CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl <= wdat[7:0];
            end
            // hardware set wins over a software clear in the same cycle
            if (collide) begin
                ctrl.write_collision <= 1'b1;
            end
            if (overrun) begin
                ctrl.receive_overflow <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            stat <= STAT_RST;
        end else begin
            if (wr_stat) begin
                stat.sample_point <= wdat[7];
                stat.clock_edge   <= wdat[6];
            end
            if (!ctrl.port_enable) begin
                stat.stop_seen <= 1'b0;
            end
            if (word_done && !overrun) begin
                stat.buffer_full <= 1'b1;
            end else if (rd_buf) begin
                stat.buffer_full <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            data_buffer <= 8'h0;
            flag        <= 1'b0;
        end else begin
            if (load) begin
                data_buffer <= wdat[7:0];
            end else if (word_done && !overrun) begin
                data_buffer <= next_word;
            end
            if (word_done) begin
                flag <= 1'b1;
            end else if (wr_flag && wdat[0]) begin
                flag <= 1'b0;
            end
        end
    end

    // ********************
    // axi4-lite slave
    // ********************
    always_ff @(posedge clk) begin
        if (reset) begin
            aw_got      <= 1'b0;
            w_got       <= 1'b0;
            axi_awready <= 1'b0;
            axi_wready  <= 1'b0;
            axi_bvalid  <= 1'b0;
            axi_bresp   <= RESP_OKAY;
            waddr       <= 8'h0;
            wdat        <= 32'h0;
            wstb        <= 4'h0;
        end else begin
            aw_got      <= aw_hs || (aw_got && !do_wr);
            w_got       <= w_hs || (w_got && !do_wr);
            axi_awready <= !(aw_hs || (aw_got && !do_wr));
            axi_wready  <= !(w_hs || (w_got && !do_wr));
            if (aw_hs) begin
                waddr <= axi_awaddr;
            end
            if (w_hs) begin
                wdat <= axi_wdata;
                wstb <= axi_wstrb;
            end
            if (do_wr) begin
                axi_bvalid <= 1'b1;
                axi_bresp  <= mapped(waddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (axi_bready) begin
                axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            axi_arready <= 1'b0;
            axi_rvalid  <= 1'b0;
            axi_rdata   <= 32'h0;
            axi_rresp   <= RESP_OKAY;
        end else begin
            axi_arready <= !(ar_hs || (axi_rvalid && !axi_rready));
            if (ar_hs) begin
                axi_rvalid <= 1'b1;
                axi_rresp  <= mapped(axi_araddr) ? RESP_OKAY : RESP_SLVERR;
                unique case (axi_araddr)
                    OFS_CTRL: axi_rdata <= {24'h0, ctrl};
                    OFS_STAT: axi_rdata <= {24'h0, stat};
                    OFS_BUF:  axi_rdata <= {24'h0, data_buffer};
                    OFS_FLAG: axi_rdata <= {31'h0, flag};
                    default:  axi_rdata <= 32'h0;
                endcase
            end else if (axi_rready) begin
                axi_rvalid <= 1'b0;
            end
        end
    end

    // ********************
    // checks
    // ********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_WRITE_COLLISION_SET: assert property (collide |=> ctrl.write_collision && state != ST_IDLE
                                   || !ctrl.port_enable)
        else $error("write during shift did not flag a collision");
    AST_MASTER_START: assert property (start |=> state == ST_MASTER
                                       && sr == $past(wdat[7:0]))
        else $error("buffer write did not start the master transfer");
    AST_NO_MASTER_OVF: assert property ($rose(ctrl.receive_overflow)
                                        |-> $past(state) == ST_SLAVE || $past(wr_ctrl))
        else $error("overflow set outside slave mode");
    AST_BF_READ: assert property (rd_buf && !word_done |=> !stat.buffer_full)
        else $error("buffer read left buffer full set");
    AST_WORD_DONE: assert property (word_done && !overrun && !load |=> stat.buffer_full
                                    && flag && data_buffer == $past(next_word))
        else $error("finished word not moved to the buffer");
    AST_OVERRUN: assert property (overrun |=> ctrl.receive_overflow
                                  && data_buffer == $past(data_buffer))
        else $error("overrun not flagged or word not dropped");
    AST_DISABLED: assert property (!ctrl.port_enable |=> !pins.owned && !pins.sck_oe
                                   && !pins.sdo_oe && !stat.stop_seen)
        else $error("disabled port still holds its pins");
    AST_IDLE_SCK: assert property (state == ST_IDLE ##1 state == ST_IDLE
                                   |-> pins.sck == $past(ctrl.clock_polarity))
        else $error("serial clock not at idle level");
    AST_SS_HIGH: assert property (state == ST_SLAVE && ss_ctl && ss_sy[1]
                                  |=> !pins.sdo_oe && tick_cnt == 5'h0 && rx_cnt == 4'h0)
        else $error("select high did not float output and clear count");
    AST_DIV4_RATE: assert property (master_tick && ctrl.mode_field == MODE_M4
                                    && tick_cnt < LAST_EDGE |=> !master_tick ##1 master_tick)
        else $error("fastest master rate is not two clocks per half period");
endmodule : ssp_spi_port

//--- testbench/ssp_far_end.sv
// Purpose: far-end serial device for the port bench
// Assumes: idle-low clock, data changed falling, taken rising
// Notes:   clocks the link itself, or follows the port's clock
`timescale 1ns/1ps
module ssp_far_end (
    // port side
    input  wire logic       dev_sck,
    input  wire logic       dev_sdo,
    // bench control
    input  wire logic       drive_clk,
    input  wire logic       sel_en,
    input  wire logic       start,
    input  wire logic [7:0] tx,
    // link
    output      logic       sck,
    output      logic       sdi,
    output      logic       ss_n,
    output      logic [7:0] rx,
    output      logic       done
);
    logic [7:0] shreg;
    wire        lclk = drive_clk ? sck : dev_sck;
    initial begin
        {sck, sdi, ss_n, done, rx, shreg} = {3'h3, 1'h0, 16'h0};
    end
    // link clock stands still outside frames; edges kept off core edges
    always @(posedge start) begin
        shreg = tx;
        sdi = tx[7];
        done = 1'h0;
        if (drive_clk) begin
            ss_n = !sel_en;
            #650;
            repeat (8) begin
                sck = 1'h1;
                #160;
                sck = 1'h0;
                #160;
            end
            #640;
            ss_n = 1'h1;
            sdi = ~sdi; // released line shows no stale bit
        end
        done = 1'h1;
    end
    always @(posedge lclk) rx <= {rx[6:0], dev_sdo};
    always @(negedge lclk) begin
        shreg = shreg << 1;
        sdi = shreg[7];
    end
endmodule : ssp_far_end

//--- testbench/tb_top.sv
// Purpose: self-checking bench of the spi mode serial port
// Assumes: 25 MHz core clock, far end clocks at 320 ns
// Notes:   register rows first, then transfers and slave cases
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %0t got %0h want %0h", $time, (g), (e)); end end
module tb_top;
    import ssp_pkg::*;
    typedef struct packed {logic [7:0] a, d, q; logic [1:0] r;} ssp_row_s;
    localparam ssp_row_s ROWS [5] = '{'{OFS_STAT, 8'hFF, 8'hC0, RESP_OKAY},
        '{OFS_STAT, 8'h00, 8'h00, RESP_OKAY}, '{OFS_CTRL, 8'h13, 8'h13, RESP_OKAY},
        '{OFS_CTRL, 8'h00, 8'h00, RESP_OKAY}, '{8'h10, 8'h5A, 8'h00, RESP_SLVERR}};
    localparam int HALF [4] = '{HALF_DIV4, HALF_DIV16, HALF_DIV64, 5};
    logic        clk, reset, axi_awvalid, axi_wvalid, axi_bready, axi_arvalid, axi_rready;
    logic [7:0]  axi_awaddr, axi_araddr, far_tx, far_rx;
    logic [31:0] axi_wdata, axi_rdata, rd;
    logic [3:0]  axi_wstrb;
    logic        axi_awready, axi_wready, axi_bvalid, axi_arready, axi_rvalid;
    logic [1:0]  axi_bresp, axi_rresp, resp;
    logic        sck_i, sdi_i, ss_n_i, drive_clk, sel_en, start, far_done, last_sck;
    logic        timer_two_tick = 1'h0;
    logic [2:0]  tdiv = 3'h0;
    ssp_pins_s   pins;
    int          fail_count, check_count, cycles, edges, gap, last_t, e0;
    ssp_spi_port ssp_spi_port_i (.clk(clk), .reset(reset), .axi_awaddr(axi_awaddr),
        .axi_awvalid(axi_awvalid), .axi_awready(axi_awready), .axi_wdata(axi_wdata),
        .axi_wstrb(axi_wstrb), .axi_wvalid(axi_wvalid), .axi_wready(axi_wready),
        .axi_bresp(axi_bresp), .axi_bvalid(axi_bvalid), .axi_bready(axi_bready),
        .axi_araddr(axi_araddr), .axi_arvalid(axi_arvalid), .axi_arready(axi_arready),
        .axi_rdata(axi_rdata), .axi_rresp(axi_rresp), .axi_rvalid(axi_rvalid),
        .axi_rready(axi_rready), .sck_i(sck_i), .sdi_i(sdi_i), .ss_n_i(ss_n_i),
        .timer_two_tick(timer_two_tick), .pins(pins));
    ssp_far_end ssp_far_end_i (.dev_sck(pins.sck), .dev_sdo(pins.sdo), .drive_clk(drive_clk),
        .sel_en(sel_en), .start(start), .tx(far_tx), .sck(sck_i), .sdi(sdi_i),
        .ss_n(ss_n_i), .rx(far_rx), .done(far_done));
    // ********************
    // clock, timer pulse, clock-edge monitor
    // ********************
    initial clk = 1'h0;
    always #20 clk = ~clk;
    always @(posedge clk) begin
        tdiv <= (tdiv == 3'h4) ? 3'h0 : tdiv + 3'h1;
        timer_two_tick <= (tdiv == 3'h4);
        cycles <= cycles + 1;
        last_sck <= pins.sck;
        if (pins.sck !== last_sck && pins.sck_oe) begin
            edges <= edges + 1;
            gap <= cycles - last_t;
            last_t <= cycles;
        end
        if (cycles > 40000) begin
            fail_count++;
            end_of_test();
        end
    end
    // ********************
    // bus tasks
    // ********************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clk);
        axi_awaddr <= a;
        axi_wdata <= {24'h0, d};
        {axi_awvalid, axi_wvalid, axi_bready} <= 3'h7;
        do begin
            @(posedge clk);
            n++;
            if (axi_awvalid && axi_awready) axi_awvalid <= 1'h0;
            if (axi_wvalid && axi_wready) axi_wvalid <= 1'h0;
        end while (axi_bvalid !== 1'h1 && n < 100);
        resp = axi_bresp;
        axi_bready <= 1'h0;
        if (n >= 100) fail_count++;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        int n = 0;
        @(posedge clk);
        axi_araddr <= a;
        {axi_arvalid, axi_rready} <= 2'h3;
        do begin
            @(posedge clk);
            n++;
            if (axi_arvalid && axi_arready) axi_arvalid <= 1'h0;
        end while (axi_rvalid !== 1'h1 && n < 100);
        rd = axi_rdata;
        resp = axi_rresp;
        axi_rready <= 1'h0;
        if (n >= 100) fail_count++;
    endtask : rdr
    task automatic wword();
        int n = 0;
        do begin
            rdr(OFS_FLAG);
            n++;
        end while (rd[0] !== 1'h1 && n < 300);
        `CHK(rd[0], 1'h1)
        wr(OFS_FLAG, 8'h01);
    endtask : wword
    task automatic widle();
        for (int n = 0; n < 600 && edges - e0 < 16; n++) @(posedge clk);
        repeat (70) @(posedge clk);
    endtask : widle
    task automatic frame(input logic [7:0] t);
        far_tx <= t;
        start <= 1'h1;
        @(posedge clk);
        start <= 1'h0;
        for (int n = 0; n < 200 && far_done !== 1'h1; n++) @(posedge clk);
    endtask : frame
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    // ********************
    // main sequence
    // ********************
    initial begin
        {reset, axi_awvalid, axi_wvalid, axi_bready, axi_arvalid, axi_rready} = 6'h20;
        {axi_awaddr, axi_araddr, axi_wdata, far_tx} = '0;
        {axi_wstrb, drive_clk, sel_en, start} = 7'h7A;
        repeat (12) @(posedge clk);
        reset <= 1'h0;
        rdr(OFS_STAT);
        `CHK(rd, 32'h0)
        foreach (ROWS[i]) begin
            wr(ROWS[i].a, ROWS[i].d);
            `CHK(resp, ROWS[i].r)
            rdr(ROWS[i].a);
            `CHK(rd, {24'h0, ROWS[i].q})
            `CHK(resp, ROWS[i].r)
        end
        wr(OFS_CTRL, 8'h30);
        // pins follow a control write one clock later
        @(negedge clk);
        `CHK({pins.owned, pins.sck_oe, pins.sck}, 3'h7)
        wr(OFS_CTRL, 8'h10);
        @(negedge clk);
        `CHK(pins.owned, 1'h0)
        // transmit on the returning edge, sample on the leading one
        wr(OFS_STAT, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CTRL, 8'h20 | m[7:0]);
            frame(8'hA5 ^ m[7:0]);
            // idle level change after enable is counted before the base
            @(negedge clk);
            e0 = edges;
            wr(OFS_BUF, 8'h3C + m[7:0]);
            wword();
            widle();
            `CHK(edges - e0, 16)
            `CHK(gap, HALF[m])
            `CHK({pins.sck, far_rx}, {1'h0, 8'h3C + m[7:0]})
            rdr(OFS_BUF);
            if (m != 0) `CHK(rd[7:0], 8'hA5 ^ m[7:0])
            rdr(OFS_STAT);
            `CHK(rd[0], 1'h0)
        end
        wr(OFS_CTRL, 8'h21);
        e0 = edges;
        wr(OFS_BUF, 8'h11);
        wr(OFS_BUF, 8'h22);
        wword();
        widle();
        `CHK(far_rx, 8'h11)
        rdr(OFS_STAT);
        `CHK(rd[0], 1'h1)
        e0 = edges;
        wr(OFS_BUF, 8'h33);
        wword();
        widle();
        rdr(OFS_CTRL);
        `CHK(rd[7:0], 8'hA1)
        wr(OFS_STAT, 8'h00);
        wr(OFS_CTRL, 8'h24);
        rdr(OFS_BUF);
        wr(OFS_BUF, 8'hC3);
        drive_clk <= 1'h1;
        frame(8'h96);
        wword();
        `CHK({far_rx, pins.sdo_oe}, {8'hC3, 1'h0})
        frame(8'h69);
        wword();
        rdr(OFS_CTRL);
        `CHK(rd[6], 1'h1)
        rdr(OFS_BUF);
        `CHK(rd[7:0], 8'h96)
        wr(OFS_CTRL, 8'h25);
        sel_en <= 1'h0;
        frame(8'h5C);
        wword();
        rdr(OFS_BUF);
        `CHK(rd[7:0], 8'h5C)
        end_of_test();
    end
endmodule : tb_top
